// File: shared/flash_selfprog_defines.svh
`ifndef FLASH_SELFPROG_DEFINES_SVH
`define FLASH_SELFPROG_DEFINES_SVH

// Operation codes in the five low bits of the self-programming control register.
`define FSP_OP_LOAD 5'h01
`define FSP_OP_ERASE 5'h03
`define FSP_OP_WRITE 5'h05
`define FSP_OP_NONE 5'h00

// Field positions of the control register and of the pointer.
`define FSP_CTRL_ENABLE_BIT 0
`define FSP_PAGE_MSB 14
`define FSP_PAGE_LSB 7
`define FSP_WORD_MSB 6
`define FSP_WORD_LSB 1

// Array geometry.
`define FSP_PAGES 256
`define FSP_PAGE_WORDS 64
`define FSP_BOOT_PAGES 4

// Cycles after a control write in which a store-program instruction is honoured.
`define FSP_SPM_WINDOW 3'h4

// Application reset address.
`define FSP_APP_RESET_WORD 14'h0000

// Agent registers on AHB-Lite (byte addresses).
`define AG_REG_CMD 32'h0000_0000
`define AG_REG_ZPTR 32'h0000_0004
`define AG_REG_DATA 32'h0000_0008
`define AG_REG_STATUS 32'h0000_000C
`define AG_REG_LPM 32'h0000_0010

// Agent command register fields.
`define AG_CMD_OP_MSB 4
`define AG_CMD_DELAY_MSB 10
`define AG_CMD_DELAY_LSB 8
`define AG_CMD_BOOT_BIT 12

`endif

// File: shared/flash_selfprog_pkg.sv
package flash_selfprog_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_ARMED = 3'b001,
    SEQ_ERASE = 3'b010,
    SEQ_STREAM = 3'b011,
    SEQ_PROG = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    AG_IDLE = 2'b00,
    AG_WAIT = 2'b01,
    AG_POLL = 2'b10
  } agent_state_t;

  typedef logic [63:0][15:0] page_buf_t;

  typedef struct packed {
    seq_state_t state;
    logic [4:0] op;
    logic [2:0] window;
    logic [7:0] page;
    logic [5:0] idx;
    page_buf_t buffer;
    logic erase;
    logic load;
    logic prog;
    logic [15:0] wdata;
    logic [13:0] rvec;
    logic rd_pend;
    logic [15:0] lpm_data;
    logic lpm_valid;
  } seq_regs_t;

  typedef struct packed {
    agent_state_t state;
    logic wr_pend;
    logic [2:0] widx;
    logic [31:0] hrdata;
    logic [4:0] op;
    logic [2:0] delay;
    logic from_boot;
    logic [2:0] count;
    logic [15:0] zptr;
    logic [15:0] dpair;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic spm;
    logic lpm_req;
    logic lpm_busy;
    logic [15:0] lpm_data;
  } agent_regs_t;

endpackage : flash_selfprog_pkg

// File: shared/selfprog_link_if.sv
`timescale 1ns/1ns
`default_nettype none

interface selfprog_link_if;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata;
  logic spm_strobe;
  logic spm_from_boot;
  logic [15:0] z_ptr;
  logic [15:0] data_pair;
  logic lpm_req;
  logic [15:0] lpm_rdata;
  logic lpm_valid;
  logic cpu_halt;

  modport dev (
    input ctrl_wr, ctrl_wdata, spm_strobe, spm_from_boot, z_ptr, data_pair, lpm_req,
    output ctrl_rdata, lpm_rdata, lpm_valid, cpu_halt
  );

  modport cpu (
    output ctrl_wr, ctrl_wdata, spm_strobe, spm_from_boot, z_ptr, data_pair, lpm_req,
    input ctrl_rdata, lpm_rdata, lpm_valid, cpu_halt
  );
endinterface : selfprog_link_if

`default_nettype wire

// File: hdl/flash_self_program_sequencer.sv
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "flash_selfprog_defines.svh"

// Behaviour
// - Fuse 0 resets to zero, 1 to boot.
// - Boot code may read everything and write all but locked boot pages.
// - General lock bits never gate store or load.
// - Flash changes only in whole 64-word pages.
// - Software erases before writing, reloads kept words.
// - Buffer loads accepted in any word order.
// - Software issues store within four cycles.
// - Code 00001 loads data pair into buffer.
// - Code 00101 programs buffer into addressed page.
// - Erase and write use the same page.
// - CPU halted during erase and page write.
// - Enable bit stays set until operation ends.
// - Software pads erase and write with filler.
// - Software keeps interrupts off while programming.
// - Boot writes allowed only while lock unprogrammed.
// - Stores from outside boot section do nothing.
// - Flash is 256 pages, boot at top.
module flash_self_program_sequencer
  import flash_selfprog_pkg::*;
#(
  parameter int PAGES = `FSP_PAGES,
  parameter int PAGE_WORDS = `FSP_PAGE_WORDS,
  parameter int BOOT_PAGES = `FSP_BOOT_PAGES
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic boot_vector_select_i,
  input wire logic boot_lock11_i,
  input wire logic flash_done_i,
  input wire logic [15:0] flash_rdata_i,
  selfprog_link_if.dev link,
  output logic [13:0] reset_vector_o,
  output logic flash_erase_o,
  output logic flash_load_o,
  output logic flash_prog_o,
  output logic [7:0] flash_page_o,
  output logic [5:0] flash_word_o,
  output logic [15:0] flash_wdata_o,
  output logic flash_rd_o,
  output logic [13:0] flash_rd_addr_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Geometry checks and derived constants.

  if (PAGES != `FSP_PAGES || PAGE_WORDS != `FSP_PAGE_WORDS)
  begin : g_geom_check
    $error("Array geometry other than 256 pages of 64 words is not supported.");
  end
  if (BOOT_PAGES < 1 || BOOT_PAGES > PAGES / 2 || (BOOT_PAGES & (BOOT_PAGES - 1)) != 0)
  begin : g_boot_check
    $error("Boot section must be a power of two pages, at most half the array.");
  end

  // The boot section sits at the top of the array.
  localparam logic [7:0] BOOT_START_PAGE = 8'(PAGES - BOOT_PAGES);
  localparam logic [13:0] BOOT_START_WORD = {BOOT_START_PAGE, 6'h00};

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  seq_regs_t st;
  seq_regs_t next_st;
  logic [7:0] z_page;
  logic [5:0] z_word;
  logic page_protected;

  assign z_page = link.z_ptr[`FSP_PAGE_MSB:`FSP_PAGE_LSB];
  assign z_word = link.z_ptr[`FSP_WORD_MSB:`FSP_WORD_LSB];
  // Only boot lock bit 11 guards the boot section; the general lock bits are not inputs.
  assign page_protected = !boot_lock11_i && (z_page >= BOOT_START_PAGE);

  always_comb
  begin
    next_st = st;
    next_st.lpm_valid = 1'b0;
    next_st.rvec = boot_vector_select_i ? BOOT_START_WORD : `FSP_APP_RESET_WORD;

    // Program-memory loads reach every location, whatever the lock bits say.
    next_st.rd_pend = link.lpm_req && !link.cpu_halt;
    if (st.rd_pend)
    begin
      next_st.lpm_data = flash_rdata_i;
      next_st.lpm_valid = 1'b1;
    end

    unique case (st.state)
      SEQ_IDLE, SEQ_ARMED:
      begin
        if (link.ctrl_wr)
        begin
          if (link.ctrl_wdata[`FSP_CTRL_ENABLE_BIT])
          begin
            next_st.op = link.ctrl_wdata[4:0];
            next_st.window = `FSP_SPM_WINDOW;
            next_st.state = SEQ_ARMED;
          end
          else
          begin
            next_st.op = `FSP_OP_NONE;
            next_st.state = SEQ_IDLE;
          end
        end
        else if (st.state == SEQ_ARMED)
        begin
          if (link.spm_strobe && link.spm_from_boot)
          begin
            next_st.op = `FSP_OP_NONE;
            next_st.state = SEQ_IDLE;
            unique case (st.op)
              `FSP_OP_LOAD:
              begin
                // Any word of the buffer may be loaded at any time.
                next_st.buffer[z_word] = link.data_pair;
              end
              `FSP_OP_ERASE:
              begin
                if (!page_protected)
                begin
                  next_st.op = st.op;
                  next_st.page = z_page;
                  next_st.erase = 1'b1;
                  next_st.state = SEQ_ERASE;
                end
              end
              `FSP_OP_WRITE:
              begin
                if (!page_protected)
                begin
                  next_st.op = st.op;
                  next_st.page = z_page;
                  next_st.idx = 6'h00;
                  next_st.wdata = st.buffer[0];
                  next_st.load = 1'b1;
                  next_st.state = SEQ_STREAM;
                end
              end
              default:
              begin
                // Unknown codes are dropped without touching flash or buffer.
                next_st.op = `FSP_OP_NONE;
              end
            endcase
          end
          else if (st.window == 3'h1)
          begin
            next_st.op = `FSP_OP_NONE;
            next_st.window = 3'h0;
            next_st.state = SEQ_IDLE;
          end
          else
          begin
            next_st.window = st.window - 3'h1;
          end
        end
      end
      SEQ_ERASE:
      begin
        if (flash_done_i)
        begin
          next_st.erase = 1'b0;
          next_st.op = `FSP_OP_NONE;
          next_st.state = SEQ_IDLE;
        end
      end
      SEQ_STREAM:
      begin
        // The whole page is handed to the array; there is no single-word path.
        if (st.idx == 6'h3F)
        begin
          next_st.load = 1'b0;
          next_st.prog = 1'b1;
          next_st.buffer = '1;
          next_st.state = SEQ_PROG;
        end
        else
        begin
          next_st.idx = st.idx + 6'h01;
          next_st.wdata = st.buffer[st.idx + 6'h01];
        end
      end
      SEQ_PROG:
      begin
        if (flash_done_i)
        begin
          next_st.prog = 1'b0;
          next_st.op = `FSP_OP_NONE;
          next_st.state = SEQ_IDLE;
        end
      end
      default:
      begin
        next_st.state = SEQ_IDLE;
        next_st.op = `FSP_OP_NONE;
        next_st.erase = 1'b0;
        next_st.load = 1'b0;
        next_st.prog = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st <= '0;
      st.buffer <= '1;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign link.cpu_halt = (st.state == SEQ_ERASE) || (st.state == SEQ_STREAM)
    || (st.state == SEQ_PROG);
  assign link.ctrl_rdata = {3'h0, st.op};
  assign link.lpm_rdata = st.lpm_data;
  assign link.lpm_valid = st.lpm_valid;
  assign reset_vector_o = st.rvec;
  assign flash_erase_o = st.erase;
  assign flash_load_o = st.load;
  assign flash_prog_o = st.prog;
  assign flash_page_o = st.page;
  assign flash_word_o = st.idx;
  assign flash_wdata_o = st.wdata;
  assign flash_rd_o = link.lpm_req && !link.cpu_halt;
  assign flash_rd_addr_o = link.z_ptr[14:1];

endmodule : flash_self_program_sequencer

`default_nettype wire

// File: hdl/cpu_store_agent.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_selfprog_defines.svh"

module cpu_store_agent
  import flash_selfprog_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  selfprog_link_if.cpu link
);

  agent_regs_t st;
  agent_regs_t next_st;
  logic addr_ok;
  logic take;
  logic busy;
  logic [31:0] rd_word;

  assign addr_ok = (haddr_i[31:5] == 27'h000_0000) && (haddr_i[4:2] <= 3'h4);
  assign take = hsel_i && htrans_i[1] && hready_i;
  // A program load in flight counts as busy until its answer has been captured.
  assign busy = (st.state != AG_IDLE) || st.lpm_busy;

  always_comb
  begin
    unique case ({27'h000_0000, haddr_i[4:0]})
      `AG_REG_CMD:
        rd_word = {19'h0_0000, st.from_boot, 1'b0, st.delay, 3'h0, st.op};
      `AG_REG_ZPTR:
        rd_word = {16'h0000, st.zptr};
      `AG_REG_DATA:
        rd_word = {16'h0000, st.dpair};
      `AG_REG_STATUS:
        rd_word = {st.lpm_data, link.ctrl_rdata, 6'h00, link.cpu_halt, busy};
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.ctrl_wr = 1'b0;
    next_st.spm = 1'b0;
    next_st.lpm_req = 1'b0;
    next_st.wr_pend = take && hwrite_i && addr_ok;
    next_st.widx = haddr_i[4:2];
    if (take && !hwrite_i)
    begin
      next_st.hrdata = addr_ok ? rd_word : 32'h0000_0000;
    end
    if (link.lpm_valid)
    begin
      next_st.lpm_data = link.lpm_rdata;
      next_st.lpm_busy = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes in the data phase; commands start only when idle.
    if (st.wr_pend)
    begin
      unique case (st.widx)
        3'h0:
        begin
          if (!busy)
          begin
            next_st.op = hwdata_i[`AG_CMD_OP_MSB:0];
            next_st.delay = hwdata_i[`AG_CMD_DELAY_MSB:`AG_CMD_DELAY_LSB];
            next_st.from_boot = hwdata_i[`AG_CMD_BOOT_BIT];
            next_st.ctrl_wr = 1'b1;
            next_st.ctrl_wdata = {3'h0, hwdata_i[`AG_CMD_OP_MSB:0]};
            next_st.count = hwdata_i[`AG_CMD_DELAY_MSB:`AG_CMD_DELAY_LSB];
            next_st.state = AG_WAIT;
          end
        end
        3'h1:
          next_st.zptr = hwdata_i[15:0];
        3'h2:
          next_st.dpair = hwdata_i[15:0];
        3'h4:
        begin
          if (!busy)
          begin
            next_st.lpm_req = 1'b1;
            next_st.lpm_busy = 1'b1;
          end
        end
        default:
          next_st.op = st.op;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Store sequence: control write, programmed gap, store, then poll.
    unique case (st.state)
      AG_IDLE:
        next_st.state = next_st.state;
      AG_WAIT:
      begin
        if (st.count == 3'h0)
        begin
          next_st.spm = 1'b1;
          next_st.state = AG_POLL;
        end
        else
        begin
          next_st.count = st.count - 3'h1;
        end
      end
      AG_POLL:
      begin
        // The filler words after a store are modelled by this wait.
        if (!st.spm && !link.cpu_halt && !link.ctrl_rdata[`FSP_CTRL_ENABLE_BIT])
        begin
          next_st.state = AG_IDLE;
        end
      end
      default:
        next_st.state = AG_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st <= '0;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = st.hrdata;
  assign link.ctrl_wr = st.ctrl_wr;
  assign link.ctrl_wdata = st.ctrl_wdata;
  assign link.spm_strobe = st.spm;
  assign link.spm_from_boot = st.from_boot;
  assign link.z_ptr = st.zptr;
  assign link.data_pair = st.dpair;
  assign link.lpm_req = st.lpm_req;

endmodule : cpu_store_agent

`default_nettype wire

// File: tb/flash_self_program_sequencer_checker.sv
`timescale 1ns/1ns
`default_nettype none

module flash_self_program_sequencer_checker (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic spm_strobe,
  input wire logic spm_from_boot,
  input wire logic [15:0] z_ptr,
  input wire logic lpm_req,
  input wire logic lpm_valid,
  input wire logic cpu_halt
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Pages 252 and up form the boot section, whose writes depend on the lock input.
  a_ctrl_arms_op: assert property (ctrl_wr && !cpu_halt && ctrl_wdata[4:0] inside {5'h01, 5'h03, 5'h05}
    |=> ctrl_rdata == {3'h0, $past(ctrl_wdata[4:0])}) else $error("control write not held");
  a_load_clears_op: assert property (spm_strobe && spm_from_boot && ctrl_rdata == 8'h01
    |=> ctrl_rdata == 8'h00 && !cpu_halt) else $error("buffer load did not finish");
  a_erase_halts_cpu: assert property (spm_strobe && spm_from_boot && ctrl_rdata == 8'h03
    && z_ptr[14:7] < 8'hfc |=> cpu_halt && ctrl_rdata == 8'h03) else $error("erase did not halt");
  a_write_halts_cpu: assert property (spm_strobe && spm_from_boot && ctrl_rdata == 8'h05
    && z_ptr[14:7] < 8'hfc |=> cpu_halt [*8]) else $error("page write did not halt");
  a_halt_keeps_enable: assert property (cpu_halt |-> ctrl_rdata[0])
    else $error("enable bit dropped while halted");
  a_window_expires: assert property (ctrl_wr && ctrl_wdata[0] && !cpu_halt ##1 !spm_strobe [*4]
    |=> ctrl_rdata == 8'h00) else $error("operation survived its window");
  a_outside_boot_ignored: assert property (spm_strobe && !spm_from_boot && !cpu_halt
    |=> !cpu_halt) else $error("store from outside boot acted");
  a_no_op_store: assert property (spm_strobe && ctrl_rdata == 8'h00
    |=> ctrl_rdata == 8'h00 && !cpu_halt) else $error("store without operation acted");
  a_load_answer: assert property (lpm_req && !cpu_halt |-> ##2 lpm_valid ##1 !lpm_valid)
    else $error("program load answer late");

  c_erase: cover property (spm_strobe && ctrl_rdata == 8'h03);
  c_write: cover property (spm_strobe && ctrl_rdata == 8'h05);
  c_load: cover property (lpm_valid);
endmodule : flash_self_program_sequencer_checker

`default_nettype wire

// File: tb/flash_self_program_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_selfprog_defines.svh"

module flash_self_program_sequencer_tb;
  typedef struct packed {
    logic [4:0] op;
    logic [2:0] gap;
    logic boot;
    logic lck;
    logic [7:0] pg;
    logic [15:0] exp;
  } case_t;

  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic fuse = 1'b0;
  logic lock = 1'b1;
  logic done = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, st;
  logic [15:0] rdata = 16'h0000;
  logic hready, hresp, erase, load, prog, rd;
  logic [13:0] rvec, rd_addr;
  logic [7:0] page;
  logic [5:0] word;
  logic [15:0] wdata;
  logic [15:0] mem [0:16383];
  logic [15:0] stage [0:63];
  logic [2:0] cnt = 3'h0;
  logic [5:0] wl [3] = '{6'h3f, 6'h00, 6'h11};
  case_t cases [7] = '{
    '{5'h03, 3'h3, 1'b1, 1'b1, 8'h09, 16'hffff}, '{5'h03, 3'h4, 1'b1, 1'b1, 8'h08, 16'h1234},
    '{5'h03, 3'h0, 1'b0, 1'b1, 8'h07, 16'h1234}, '{5'h03, 3'h0, 1'b1, 1'b1, 8'hff, 16'hffff},
    '{5'h03, 3'h0, 1'b1, 1'b0, 8'hfe, 16'h1234}, '{5'h00, 3'h0, 1'b1, 1'b1, 8'h0a, 16'h1234},
    '{5'h11, 3'h0, 1'b1, 1'b1, 8'h0b, 16'h1234}};
  int errors = 0;
  int n_compared = 0;

  always #2 mclk_i = ~mclk_i;

  selfprog_link_if link();

  flash_self_program_sequencer u_flash_self_program_sequencer (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1), .boot_vector_select_i(fuse),
    .boot_lock11_i(lock), .flash_done_i(done), .flash_rdata_i(rdata), .link(link),
    .reset_vector_o(rvec), .flash_erase_o(erase), .flash_load_o(load), .flash_prog_o(prog),
    .flash_page_o(page), .flash_word_o(word), .flash_wdata_o(wdata), .flash_rd_o(rd),
    .flash_rd_addr_o(rd_addr));

  cpu_store_agent u_cpu_store_agent (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .link(link));

  flash_self_program_sequencer_checker u_checker (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ctrl_wr(link.ctrl_wr),
    .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata), .spm_strobe(link.spm_strobe),
    .spm_from_boot(link.spm_from_boot), .z_ptr(link.z_ptr), .lpm_req(link.lpm_req),
    .lpm_valid(link.lpm_valid), .cpu_halt(link.cpu_halt));

  ////////////////////////////////////////////////////////////////////////////////
  // Flash array: erase sets ones, programming can only clear bits of the page.
  always @(posedge mclk_i)
  begin
    cnt <= (erase || prog) ? cnt + 3'h1 : 3'h0;
    done <= (erase || prog) && cnt == 3'h4;
    if (rd) rdata <= mem[rd_addr];
    if (load) stage[word] <= wdata;
    for (int i = 0; i < 64; i++)
    begin
      if (erase && done) mem[{page, i[5:0]}] <= 16'hffff;
      if (prog && done) mem[{page, i[5:0]}] <= mem[{page, i[5:0]}] & stage[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic hold();
    int n;
    n = 0;
    @(posedge mclk_i);
    while (hready !== 1'b1 && n < 50)
    begin
      @(posedge mclk_i);
      n++;
    end
    if (n == 50)
    begin
      errors++;
      summarize();
    end
  endtask : hold

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold();
    st = hrdata;
  endtask : ahb

  task automatic wait_idle();
    int n;
    n = 0;
    ahb(1'b0, `AG_REG_STATUS, 32'h0000_0000);
    while (st[1:0] !== 2'h0 && n < 200)
    begin
      ahb(1'b0, `AG_REG_STATUS, 32'h0000_0000);
      n++;
    end
    if (n == 200)
    begin
      errors++;
      summarize();
    end
  endtask : wait_idle

  task automatic run_op(input logic [4:0] op, input logic [2:0] gap, input logic boot,
                        input logic [15:0] z, input logic [15:0] d);
    ahb(1'b1, `AG_REG_ZPTR, {16'h0000, z});
    ahb(1'b1, `AG_REG_DATA, {16'h0000, d});
    ahb(1'b1, `AG_REG_CMD, {19'h0_0000, boot, 1'b0, gap, 3'h0, op});
    wait_idle();
  endtask : run_op

  task automatic lpm_check(input string what, input logic [15:0] z, input logic [15:0] exp);
    ahb(1'b1, `AG_REG_ZPTR, {16'h0000, z});
    ahb(1'b1, `AG_REG_LPM, 32'h0000_0000);
    wait_idle();
    cmp(what, {16'h0000, exp}, {16'h0000, st[31:16]});
  endtask : lpm_check

  task automatic rst();
    resetn_i <= 1'b0;
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask : rst

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = 16'h1234;
    rst();
    cmp("vector", 32'h0000_0000, {18'h0_0000, rvec});
    fuse <= 1'b1;
    rst();
    cmp("vector", 32'h0000_3f00, {18'h0_0000, rvec});
    foreach (cases[i])
    begin
      lock <= cases[i].lck;
      run_op(cases[i].op, cases[i].gap, cases[i].boot, {1'b0, cases[i].pg, 7'h00}, 16'h0000);
      cmp("control", 32'h0000_0000, {24'h00_0000, st[15:8]});
      lpm_check("page", {1'b0, cases[i].pg, 7'h00}, cases[i].exp);
    end
    lock <= 1'b1;
    run_op(5'h03, 3'h0, 1'b1, 16'h02d5, 16'hbeef);
    foreach (wl[i])
      run_op(5'h01, 3'h0, 1'b1, {9'h005, wl[i], 1'b0}, {10'h028, wl[i]});
    run_op(5'h05, 3'h0, 1'b1, 16'h0280, 16'h0000);
    foreach (wl[i])
      lpm_check("word", {9'h005, wl[i], 1'b0}, {10'h028, wl[i]});
    lpm_check("unloaded", 16'h0282, 16'hffff);
    lpm_check("neighbour", 16'h0300, 16'h1234);
    summarize();
  end
endmodule : flash_self_program_sequencer_tb

`default_nettype wire
